// ==== rtl/cff_pkg.sv ====
package cff_pkg;

  // register offsets
  localparam logic [7:0] CFF_ADDR_SUMMARY = 8'h18;
  localparam logic [7:0] CFF_ADDR_EV01 = 8'h19;
  localparam logic [7:0] CFF_ADDR_EV23 = 8'h1a;
  localparam logic [7:0] CFF_ADDR_THERM = 8'h1b;
  localparam logic [7:0] CFF_ADDR_LIVE01 = 8'h1c;
  localparam logic [7:0] CFF_ADDR_LIVE23 = 8'h1d;
  localparam logic [7:0] CFF_ADDR_MASK01 = 8'h1f;
  localparam logic [7:0] CFF_ADDR_MASK23 = 8'h20;

  // layout: one nibble per core, core 0/2 low, core 1/3 high
  localparam int CFF_NUM_CORES = 4;
  localparam int CFF_NIBBLE = 4;
  localparam int CFF_EV_ILIM_BIT = 0;
  localparam int CFF_EV_SC_BIT = 1;
  localparam int CFF_EV_PG_BIT = 2;
  localparam int CFF_LIVE_ILIM_BIT = 0;
  localparam int CFF_LIVE_PG_BIT = 2;
  localparam int CFF_LIVE_EN_BIT = 3;
  localparam int CFF_MASK_ILIM_BIT = 0;
  localparam int CFF_MASK_PG_BIT = 2;
  localparam int CFF_THERM_WARN_BIT = 2;
  localparam int CFF_THERM_SD_BIT = 3;
  localparam int CFF_SUMMARY_BASE = 4;

  // reset values
  localparam logic [7:0] CFF_EV_RESET = 8'h00;
  localparam logic [7:0] CFF_MASK_RESET = 8'h55;
  localparam logic [7:0] CFF_MASK_WRITABLE = 8'h55;
  localparam logic [7:0] CFF_ZERO_BYTE = 8'h00;

  // start-up timeout: 1 ms at a 5 ns clock
  localparam int CFF_CLK_PERIOD_PS = 5000;
  localparam int CFF_PS_PER_MS = 1000000000;
  localparam int CFF_STARTUP_TIMEOUT_MS = 1;
  localparam int CFF_STARTUP_CYCLES = (CFF_STARTUP_TIMEOUT_MS * CFF_PS_PER_MS) / CFF_CLK_PERIOD_PS;
  localparam int CFF_TMR_W = 18;

  // live analog conditions of one core
  typedef struct packed {
    logic enabled;
    logic above_pgood;
    logic above_short;
    logic currlim;
  } cff_live_s;

  // latched events of one core
  typedef struct packed {
    logic pgood;
    logic shorted;
    logic currlim;
  } cff_event_s;

  // start-up tracking states
  typedef enum logic [2:0] {
    CFF_ST_OFF = 3'b001,
    CFF_ST_RAMP = 3'b010,
    CFF_ST_RUN = 3'b100
  } cff_state_e;

endpackage

// ==== rtl/cff_core_events.sv ====
`timescale 1ns/1ps
module cff_core_events import cff_pkg::*; #(
  parameter int STARTUP_CYCLES = CFF_STARTUP_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // live conditions and write-one clear
  input wire cff_live_s i_live,
  input wire cff_event_s i_clear,
  // latched flags
  output cff_event_s o_flags
);

  localparam logic [CFF_TMR_W-1:0] TMR_LAST = CFF_TMR_W'(STARTUP_CYCLES - 1);
  localparam logic [CFF_TMR_W-1:0] TMR_ONE = CFF_TMR_W'(1);
  localparam logic [CFF_TMR_W-1:0] TMR_ZERO = CFF_TMR_W'(0);

  cff_state_e state_reg, state_next; // start-up tracker
  logic [CFF_TMR_W-1:0] timer_reg, timer_next; // cycles spent in the ramp state, zero otherwise
  logic prev_pg_reg; // last power-good level, for the rising edge
  cff_event_s flags_reg, flags_next;
  cff_event_s set_ev; // events seen this cycle

  wire timeout_hit = (state_reg == CFF_ST_RAMP) && (timer_reg == TMR_LAST) && !i_live.above_short;

  // next state: off -> ramping on enable, running once the output is up or the start-up timeout hits
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      CFF_ST_OFF: begin
        if (i_live.enabled) begin
          state_next = CFF_ST_RAMP;
        end
      end
      CFF_ST_RAMP: begin
        if (!i_live.enabled) begin
          state_next = CFF_ST_OFF;
        end else if (i_live.above_short || timeout_hit) begin
          state_next = CFF_ST_RUN;
        end
      end
      CFF_ST_RUN: begin
        if (!i_live.enabled) begin
          state_next = CFF_ST_OFF;
        end
      end
    endcase
  end

  // timer only runs while ramping
  assign timer_next = (state_reg == CFF_ST_RAMP) ? timer_reg + TMR_ONE : TMR_ZERO;

  // event sources
  assign set_ev.pgood = i_live.above_pgood && !prev_pg_reg; // RULE1
  assign set_ev.shorted = timeout_hit // RULE3
    || ((state_reg == CFF_ST_RUN) && i_live.enabled && !i_live.above_short); // RULE2
  assign set_ev.currlim = i_live.currlim; // RULE4

  // set beats clear so no event is lost
  assign flags_next = (flags_reg & ~i_clear) | set_ev; // RULE5

  // state registers
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_reg <= CFF_ST_OFF;
      timer_reg <= TMR_ZERO;
      prev_pg_reg <= 1'b0;
      flags_reg <= '0;
    end else begin
      state_reg <= state_next;
      timer_reg <= timer_next;
      prev_pg_reg <= i_live.above_pgood;
      flags_reg <= flags_next;
    end
  end

  assign o_flags = flags_reg;

  // a ramp that never reaches the level ends in a short flag
  sequence s_ramp_stuck;
    (state_reg == CFF_ST_RAMP) && (timer_reg == TMR_LAST) && i_live.enabled && !i_live.above_short;
  endsequence

  a_startup_timeout: assert property (@(posedge i_clock) disable iff (i_reset) // RULE3
    s_ramp_stuck |=> flags_reg.shorted && (state_reg == CFF_ST_RUN))
    else $error("start-up timeout did not set short flag");

  a_pgood_edge: assert property (@(posedge i_clock) disable iff (i_reset) // RULE1
    (i_live.above_pgood && !prev_pg_reg) |=> flags_reg.pgood)
    else $error("power-good edge not latched");

  a_short_running: assert property (@(posedge i_clock) disable iff (i_reset) // RULE2
    ((state_reg == CFF_ST_RUN) && i_live.enabled && !i_live.above_short) |=> flags_reg.shorted)
    else $error("running short not latched");

  a_currlim_hold: assert property (@(posedge i_clock) disable iff (i_reset) // RULE4
    (flags_reg.currlim && !i_clear.currlim) |=> flags_reg.currlim)
    else $error("current-limit flag dropped without clear");

  a_clear_pgood: assert property (@(posedge i_clock) disable iff (i_reset) // RULE5
    (i_clear.pgood && !set_ev.pgood) |=> !flags_reg.pgood)
    else $error("write one did not clear power-good flag");

endmodule // cff_core_events

// ==== rtl/cff_fault_flags.sv ====
`timescale 1ns/1ps
// What this block does
// RULE1: latch power-good reached event per core
// RULE2: latch short when running output below 0.35V
// RULE3: latch short if no rise within 1 ms
// RULE4: latch current-limit event while limiting active
// RULE5: writing one clears flag, zero leaves it
// RULE6: read-only live thermal shutdown bit
// RULE7: read-only live thermal warning bit
// RULE8: per-core read-only enabled status bit
// RULE9: per-core power-good status, inverted sense
// RULE10: per-core read-only current-limit status bit
// RULE11: live status bits unlatched, writes ignored
// RULE12: mask bit blocks interrupt, not status
// RULE13: per-core summary set while any flag pending
// RULE14: interrupt active while unmasked flag pending
// RULE15: reserved bits read zero, ignore writes
module cff_fault_flags import cff_pkg::*; #(
  parameter int STARTUP_CYCLES = CFF_STARTUP_CYCLES
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // register access port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_write,
  input wire logic i_reg_read,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  // live conditions from the analog side
  input wire cff_live_s [CFF_NUM_CORES-1:0] i_core_live,
  input wire logic i_thermal_shutdown,
  input wire logic i_thermal_warning,
  // interrupt, active high
  output logic o_irq
);

  cff_event_s [CFF_NUM_CORES-1:0] flags; // latched events per core
  cff_event_s [CFF_NUM_CORES-1:0] clear; // write-one strobes per core
  logic [CFF_NUM_CORES-1:0] core_pending; // summary per core
  logic [CFF_NUM_CORES-1:0] core_unmasked; // pending and allowed to interrupt
  logic [7:0] mask01_reg, mask01_next;
  logic [7:0] mask23_reg, mask23_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  // write decodes
  wire wr_ev01 = i_reg_write && (i_reg_addr == CFF_ADDR_EV01);
  wire wr_ev23 = i_reg_write && (i_reg_addr == CFF_ADDR_EV23);
  wire wr_mask01 = i_reg_write && (i_reg_addr == CFF_ADDR_MASK01);
  wire wr_mask23 = i_reg_write && (i_reg_addr == CFF_ADDR_MASK23);

  // assembled read images
  logic [7:0] ev01_img, ev23_img, live01_img, live23_img, therm_img, summary_img;
  logic [15:0] ev_all, live_all, mask_all;
  assign mask_all = {mask23_reg, mask01_reg};

  // one slice per core: flag logic, images and mask gating
  for (genvar c = 0; c < CFF_NUM_CORES; c++) begin : g_core
    localparam int LO = c * CFF_NIBBLE;
    wire wr_this = (c < 2) ? wr_ev01 : wr_ev23;
    // only ones written into this core's nibble clear anything
    assign clear[c].pgood = wr_this && i_reg_wdata[(LO % 8) + CFF_EV_PG_BIT]; // RULE5
    assign clear[c].shorted = wr_this && i_reg_wdata[(LO % 8) + CFF_EV_SC_BIT]; // RULE5
    assign clear[c].currlim = wr_this && i_reg_wdata[(LO % 8) + CFF_EV_ILIM_BIT]; // RULE5

    cff_core_events #(
      .STARTUP_CYCLES(STARTUP_CYCLES)
    ) u_events (
      .i_clock(i_clock),
      .i_reset(i_reset),
      .i_live(i_core_live[c]),
      .i_clear(clear[c]),
      .o_flags(flags[c])
    );

    // event image: bit 3 reserved, reads zero
    assign ev_all[LO +: CFF_NIBBLE] = {1'b0, flags[c].pgood, flags[c].shorted, flags[c].currlim}; // RULE15
    // live image: bit 1 reserved; power-good reads 1 when below threshold
    assign live_all[LO + CFF_LIVE_EN_BIT] = i_core_live[c].enabled; // RULE8
    assign live_all[LO + CFF_LIVE_PG_BIT] = !i_core_live[c].above_pgood; // RULE9
    assign live_all[LO + 1] = 1'b0; // RULE15
    assign live_all[LO + CFF_LIVE_ILIM_BIT] = i_core_live[c].currlim; // RULE10
    assign core_pending[c] = |flags[c]; // RULE13
    // short events have no mask bit and always interrupt
    assign core_unmasked[c] = (flags[c].pgood && !mask_all[LO + CFF_MASK_PG_BIT]) // RULE12
      || (flags[c].currlim && !mask_all[LO + CFF_MASK_ILIM_BIT]) // RULE12
      || flags[c].shorted;
  end

  assign ev01_img = ev_all[7:0];
  assign ev23_img = ev_all[15:8];
  assign live01_img = live_all[7:0];
  assign live23_img = live_all[15:8];
  // thermal image: only bits 3 and 2 are live
  assign therm_img = {4'h0, i_thermal_shutdown, i_thermal_warning, 2'h0}; // RULE6 RULE7
  // summary image: upper nibble only, other sources live elsewhere
  assign summary_img = {core_pending, 4'h0}; // RULE13

  // masks keep only their defined bits; mask registers never touch live images
  assign mask01_next = wr_mask01 ? (i_reg_wdata & CFF_MASK_WRITABLE) : mask01_reg; // RULE12 RULE15
  assign mask23_next = wr_mask23 ? (i_reg_wdata & CFF_MASK_WRITABLE) : mask23_reg; // RULE12 RULE15

  // read mux; live bits pass straight through, unmapped reads zero
  assign rdata_next = !i_reg_read ? rdata_reg :
    (i_reg_addr == CFF_ADDR_SUMMARY) ? summary_img :
    (i_reg_addr == CFF_ADDR_EV01) ? ev01_img :
    (i_reg_addr == CFF_ADDR_EV23) ? ev23_img :
    (i_reg_addr == CFF_ADDR_THERM) ? therm_img : // RULE11
    (i_reg_addr == CFF_ADDR_LIVE01) ? live01_img : // RULE11
    (i_reg_addr == CFF_ADDR_LIVE23) ? live23_img : // RULE11
    (i_reg_addr == CFF_ADDR_MASK01) ? mask01_reg :
    (i_reg_addr == CFF_ADDR_MASK23) ? mask23_reg : CFF_ZERO_BYTE;

  // interrupt follows the flags; registered so the pin never glitches
  assign irq_next = |core_unmasked; // RULE14

  // register state
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      mask01_reg <= CFF_MASK_RESET;
      mask23_reg <= CFF_MASK_RESET;
      rdata_reg <= CFF_ZERO_BYTE;
      irq_reg <= 1'b0;
    end else begin
      mask01_reg <= mask01_next;
      mask23_reg <= mask23_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign o_reg_rdata = rdata_reg;
  assign o_irq = irq_reg;

  // a read of an address shows its image one edge later
  sequence s_read_at(logic [7:0] a);
    i_reg_read && (i_reg_addr == a);
  endsequence

  a_irq_unmasked: assert property (@(posedge i_clock) disable iff (i_reset) // RULE14
    (|core_unmasked) |=> o_irq)
    else $error("interrupt not raised for unmasked flag");

  a_irq_release: assert property (@(posedge i_clock) disable iff (i_reset) // RULE14
    !(|core_unmasked) |=> !o_irq)
    else $error("interrupt held with nothing pending");

  a_mask_blocks: assert property (@(posedge i_clock) disable iff (i_reset) // RULE12
    (flags[0] == 3'b100 && mask01_reg[CFF_MASK_PG_BIT] && flags[1] == 3'b000
      && flags[2] == 3'b000 && flags[3] == 3'b000) |=> !o_irq)
    else $error("masked power-good event raised interrupt");

  a_therm_read: assert property (@(posedge i_clock) disable iff (i_reset) // RULE6
    s_read_at(CFF_ADDR_THERM) |=> (o_reg_rdata[CFF_THERM_SD_BIT] == $past(i_thermal_shutdown))
      && (o_reg_rdata[CFF_THERM_WARN_BIT] == $past(i_thermal_warning)))
    else $error("thermal status read mismatch");

  a_live_pg_sense: assert property (@(posedge i_clock) disable iff (i_reset) // RULE9
    s_read_at(CFF_ADDR_LIVE01) |=> o_reg_rdata[CFF_LIVE_PG_BIT] == !$past(i_core_live[0].above_pgood))
    else $error("power-good status sense wrong");

  a_live_enable: assert property (@(posedge i_clock) disable iff (i_reset) // RULE8
    s_read_at(CFF_ADDR_LIVE23) |=> o_reg_rdata[CFF_NIBBLE + CFF_LIVE_EN_BIT] == $past(i_core_live[3].enabled))
    else $error("core enable status wrong");

  a_live_ilim: assert property (@(posedge i_clock) disable iff (i_reset) // RULE10
    s_read_at(CFF_ADDR_LIVE01) |=> o_reg_rdata[CFF_NIBBLE + CFF_LIVE_ILIM_BIT] == $past(i_core_live[1].currlim))
    else $error("current-limit status wrong");

  a_summary_read: assert property (@(posedge i_clock) disable iff (i_reset) // RULE13
    s_read_at(CFF_ADDR_SUMMARY) |=> o_reg_rdata == {$past(core_pending), 4'h0})
    else $error("summary bits wrong");

  a_reserved_zero: assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
    s_read_at(CFF_ADDR_EV01) |=> (o_reg_rdata[7] == 1'b0) && (o_reg_rdata[3] == 1'b0))
    else $error("reserved event bits not zero");

  a_mask_reserved: assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
    wr_mask23 |=> (mask23_reg & ~CFF_MASK_WRITABLE) == CFF_ZERO_BYTE)
    else $error("reserved mask bits stored");

  // a zero written over a pending flag must leave it standing
  a_zero_keeps: assert property (@(posedge i_clock) disable iff (i_reset) // RULE5
    (wr_ev01 && !i_reg_wdata[CFF_EV_PG_BIT] && flags[0].pgood) |=> flags[0].pgood)
    else $error("zero write cleared power-good flag");

  // read data is a register, so it only moves on a read
  a_rdata_hold: assert property (@(posedge i_clock) disable iff (i_reset) // RULE11
    !i_reg_read |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");

  // live enable of core 2 comes from the present level, not a latch
  a_live_unlatched: assert property (@(posedge i_clock) disable iff (i_reset) // RULE11
    s_read_at(CFF_ADDR_LIVE23) |=> o_reg_rdata[CFF_LIVE_EN_BIT] == $past(i_core_live[2].enabled))
    else $error("live enable status latched");

  // a set mask bit must not bend the raw power-good status
  a_mask_status: assert property (@(posedge i_clock) disable iff (i_reset) // RULE12
    (s_read_at(CFF_ADDR_LIVE01) ##0 mask01_reg[CFF_MASK_PG_BIT])
      |=> o_reg_rdata[CFF_LIVE_PG_BIT] == !$past(i_core_live[0].above_pgood))
    else $error("mask altered power-good status");

  // thermal register holds only two live bits
  a_therm_reserved: assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
    s_read_at(CFF_ADDR_THERM) |=> (o_reg_rdata[7:4] == 4'h0) && (o_reg_rdata[1:0] == 2'h0))
    else $error("reserved thermal bits not zero");

  // the gap bit in both nibbles of the core 0/1 live register reads zero
  a_live_reserved: assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
    s_read_at(CFF_ADDR_LIVE01) |=> !o_reg_rdata[CFF_NIBBLE + 1] && !o_reg_rdata[1])
    else $error("reserved live bits not zero");

  // shorts have no mask, so a pending one always interrupts
  a_short_irq: assert property (@(posedge i_clock) disable iff (i_reset) // RULE14
    flags[2].shorted |=> o_irq)
    else $error("short flag did not raise interrupt");

  // offsets past the last mask register read as zero
  a_unmapped_zero: assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
    (i_reg_read && (i_reg_addr > CFF_ADDR_MASK23)) |=> o_reg_rdata == CFF_ZERO_BYTE)
    else $error("unmapped read not zero");

endmodule // cff_fault_flags

// ==== sim/cff_analog_model.sv ====
`timescale 1ns/1ps
// behavioural stand-in for the four converter cores and their sensing
module cff_analog_model import cff_pkg::*; (
  // clock
  input wire logic i_clock,
  // per-core controls from the bench
  input wire logic [3:0] i_en,
  input wire logic [3:0] i_ramp_ok,
  input wire logic [3:0] i_drop,
  input wire logic [3:0] i_ilim,
  // live conditions toward the flag logic
  output cff_live_s [CFF_NUM_CORES-1:0] o_live
);
  int cnt [CFF_NUM_CORES]; // cycles since enable, saturating
  initial o_live = '0;
  // outputs change on the rising edge by nonblocking update, so the flag logic sees them a cycle later
  always @(posedge i_clock) begin
    for (int c = 0; c < CFF_NUM_CORES; c++) begin
      cnt[c] <= i_en[c] ? ((cnt[c] < 7) ? cnt[c] + 1 : cnt[c]) : 0;
      o_live[c].enabled <= i_en[c];
      // a failed ramp never crosses the short level, so the start-up timeout must catch it
      o_live[c].above_short <= i_en[c] && i_ramp_ok[c] && cnt[c] >= 3 && !i_drop[c];
      // power-good trails the short level, as a real ramp would
      o_live[c].above_pgood <= i_en[c] && i_ramp_ok[c] && cnt[c] >= 5 && !i_drop[c];
      o_live[c].currlim <= i_ilim[c];
    end
  end
endmodule // cff_analog_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench import cff_pkg::*;;
  localparam int SIM_STARTUP = 20; // shortened start-up timeout
  logic i_clock;
  logic i_reset;
  logic [7:0] reg_addr;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic therm_sd;
  logic therm_warn;
  logic o_irq;
  logic [3:0] en, ok, drop, ilim; // core controls for the model
  cff_live_s [CFF_NUM_CORES-1:0] core_live;
  int error_cnt = 0;
  int num_checks = 0;
  // reset image: live bits show every core disabled and below power-good
  logic [7:0] rst_addr [9] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1f, 8'h20, 8'h30};
  logic [7:0] rst_exp [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h44, 8'h44, 8'h55, 8'h55, 8'h00};

  cff_fault_flags #(.STARTUP_CYCLES(SIM_STARTUP)) dut (.i_clock(i_clock), .i_reset(i_reset),
    .i_reg_addr(reg_addr), .i_reg_write(reg_write), .i_reg_read(reg_read), .i_reg_wdata(reg_wdata),
    .o_reg_rdata(reg_rdata), .i_core_live(core_live), .i_thermal_shutdown(therm_sd),
    .i_thermal_warning(therm_warn), .o_irq(o_irq));
  cff_analog_model model (.i_clock(i_clock), .i_en(en), .i_ramp_ok(ok), .i_drop(drop), .i_ilim(ilim),
    .o_live(core_live));

  // 200 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end

  // verdict and end of run
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one strobe cycle, then an idle cycle so a strobe is never re-driven in one step
  task automatic reg_rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge i_clock);
    reg_addr = addr;
    reg_read = 1'b1;
    @(negedge i_clock);
    reg_read = 1'b0;
    check($sformatf("reg_%h", addr), exp, reg_rdata);
  endtask
  task automatic reg_wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    reg_addr = addr;
    reg_wdata = data;
    reg_write = 1'b1;
    @(negedge i_clock);
    reg_write = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_clock);
  endtask
  task automatic irq_chk(input logic exp);
    check("irq", {7'h00, exp}, {7'h00, o_irq});
  endtask

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_clock);
    error_cnt++;
    complete_run;
  end

  // main sequence
  initial begin
    i_reset = 1'b1;
    {reg_addr, reg_wdata, reg_write, reg_read} = '0;
    {therm_sd, therm_warn} = 2'b00;
    {en, ok, drop, ilim} = '0;
    repeat (4) @(posedge i_clock);
    @(negedge i_clock);
    i_reset = 1'b0;
    for (int k = 0; k < 9; k++) reg_rd(rst_addr[k], rst_exp[k]);
    irq_chk(1'b0);
    reg_wr(8'h1f, 8'hff);
    reg_rd(8'h1f, 8'h55);
    reg_wr(8'h1f, 8'h00);
    reg_rd(8'h1f, 8'h00);
    // thermal bits follow the die, writes ignored
    for (int k = 0; k < 4; k++) begin
      {therm_sd, therm_warn} = k[1:0];
      reg_wr(8'h1b, 8'hff);
      reg_rd(8'h1b, {4'h0, k[1:0], 2'b00});
    end
    // core 0 ramps up cleanly
    ok = 4'hf;
    en[0] = 1'b1;
    idle(10);
    reg_rd(8'h1c, 8'h48);
    reg_rd(8'h19, 8'h04);
    reg_rd(8'h18, 8'h10);
    irq_chk(1'b1);
    reg_wr(8'h1f, 8'h04);
    idle(2);
    irq_chk(1'b0);
    reg_rd(8'h1c, 8'h48);
    reg_wr(8'h19, 8'hfb);
    reg_rd(8'h19, 8'h04);
    reg_wr(8'h19, 8'h04);
    reg_rd(8'h19, 8'h00);
    reg_rd(8'h18, 8'h00);
    // core 1 current limiting for a short burst
    ilim[1] = 1'b1;
    idle(2);
    reg_rd(8'h1c, 8'h58);
    irq_chk(1'b1);
    ilim[1] = 1'b0;
    idle(2);
    reg_rd(8'h1c, 8'h48);
    reg_rd(8'h19, 8'h10);
    reg_wr(8'h19, 8'h10);
    reg_rd(8'h19, 8'h00);
    idle(2);
    irq_chk(1'b0);
    // core 2 never crosses the short level after enable
    ok[2] = 1'b0;
    en[2] = 1'b1;
    idle(SIM_STARTUP - 8);
    reg_rd(8'h1a, 8'h00);
    idle(SIM_STARTUP);
    reg_rd(8'h1a, 8'h02);
    irq_chk(1'b1);
    reg_rd(8'h1d, 8'h4c);
    en[2] = 1'b0;
    idle(2);
    reg_wr(8'h1a, 8'h02);
    reg_rd(8'h1a, 8'h00);
    // core 3 runs, then its output collapses
    en[3] = 1'b1;
    idle(10);
    reg_rd(8'h1a, 8'h40);
    irq_chk(1'b0);
    drop[3] = 1'b1;
    idle(3);
    reg_rd(8'h1a, 8'h60);
    irq_chk(1'b1);
    reg_rd(8'h18, 8'h80);
    {en[3], drop[3]} = 2'b00;
    idle(2);
    reg_wr(8'h1a, 8'hff);
    reg_rd(8'h1a, 8'h00);
    idle(2);
    irq_chk(1'b0);
    complete_run;
  end
endmodule // testbench
